// ### cfg_map.svh
/*
 Constants of the configuration command interpreter: parameter codes,
 reset values, ASCII codes and timing. Included by the device and host modules.
*/
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH
// Parameter codes (binary command codes)
`define CODE_DEST 6'h00
`define CODE_WAKE_DELAY 6'h03
`define CODE_GUARD_BEFORE 6'h04
`define CODE_GUARD_AFTER 6'h05
`define CODE_IDLE_TIMEOUT 6'h06
`define CODE_SW_HS 6'h07
`define CODE_COMMIT 6'h08
`define CODE_LEAVE 6'h09
`define CODE_WAKE_LEN 6'h0C
`define CODE_RX_FAIL 6'h0F
`define CODE_RX_GOOD 6'h10
`define CODE_HOP 6'h11
`define CODE_MASK 6'h12
`define CODE_ESC 6'h13
`define CODE_RATE 6'h15
`define CODE_IN2 6'h16
`define CODE_OUT2 6'h1F
`define CODE_HOLD_OFF 6'h24
`define CODE_TAG 6'h27
`define CODE_OUT3 6'h28
// Reset values
`define RST_DEST 16'h0000
`define RST_WAKE_DELAY 16'hFFFF
`define RST_GUARD 16'h000A
`define RST_IDLE_TIMEOUT 16'h00C8
`define RST_WAKE_LEN 16'h0001
`define RST_MASK 16'hFFFF
`define RST_ESC 16'h002B
`define RST_ZERO 16'h0000
// Text names, two ASCII letters each
`define TXT_DEST 16'h4454
`define TXT_WAKE_DELAY 16'h4854
`define TXT_GUARD_BEFORE 16'h4254
`define TXT_GUARD_AFTER 16'h4154
`define TXT_IDLE_TIMEOUT 16'h4354
`define TXT_SW_HS 16'h464C
`define TXT_COMMIT 16'h5752
`define TXT_LEAVE 16'h434E
`define TXT_WAKE_LEN 16'h4C48
`define TXT_RX_FAIL 16'h4552
`define TXT_RX_GOOD 16'h4744
`define TXT_HOP 16'h4850
`define TXT_MASK 16'h4D4B
`define TXT_ESC 16'h4343
`define TXT_RATE 16'h4244
`define TXT_IN2 16'h5254
`define TXT_OUT2 16'h4353
`define TXT_HOLD_OFF 16'h4654
`define TXT_TAG 16'h4944
`define TXT_OUT3 16'h4344
// ASCII
`define CH_CR 8'h0D
`define CH_COMMA 8'h2C
`define CH_A 8'h41
`define CH_T 8'h54
`define CH_O 8'h4F
`define CH_K 8'h4B
`define CH_E 8'h45
`define CH_R 8'h52
// Timing
`define CLK_KHZ 50000
`define TICK_MS 100
`define BIN_TIMEOUT_MS 500
`define BIN_TIMEOUT_TICKS (`BIN_TIMEOUT_MS / `TICK_MS)
`define TICK_CYC (`TICK_MS * `CLK_KHZ)
`define BIN_READ_FLAG 8'h80
// Host register offsets
`define HREG_TX 4'h0
`define HREG_PIN 4'h4
`define HREG_RX 4'h8
`define HREG_STATUS 4'hC
`endif

// ### cfg_pkg.sv
/*
 Types of the configuration command interpreter.
 Assumes cfg_map.svh is on the include path.
*/
`default_nettype none
package cfg_pkg;
   typedef enum logic [3:0] {
      P_DATA = 4'h0, P_ESC = 4'h1, P_GUARD = 4'h2, P_A = 4'h3, P_T = 4'h4,
      P_L1 = 4'h5, P_L2 = 4'h6, P_VAL = 4'h7, P_FIN = 4'h8
   } text_state_t;
   typedef enum logic [1:0] {B_IDLE = 2'h0, B_LO = 2'h1, B_HI = 2'h2} bin_state_t;
   typedef enum logic [1:0] {M_OK = 2'h0, M_ERR = 2'h1, M_VAL = 2'h2, M_BIN = 2'h3} msg_kind_t;
endpackage : cfg_pkg
`default_nettype wire

// ### cfg_link_if.sv
/*
 Byte-level serial link between host and configuration device.
 UART framing lies outside; one valid pulse carries one byte.
*/
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
   logic [7:0] h_data;
   logic h_valid;
   logic bin_pin;
   logic [7:0] d_data;
   logic d_valid;
   logic cts_n;
   modport dev (input h_data, h_valid, bin_pin, output d_data, d_valid, cts_n);
   modport host (output h_data, h_valid, bin_pin, input d_data, d_valid, cts_n);
endinterface : cfg_link_if
`default_nettype wire

// ### tick_divider.sv
/*
 Divides clk_sys into a one-cycle enable pulse every DIV cycles.
 Assumes DIV is at least 2.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 5000000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Enable out
   output logic tick
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt;
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cnt <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= (cnt == W'(DIV - 1));
         cnt <= (cnt == W'(DIV - 1)) ? '0 : cnt + 1'b1;
      end
   end
endmodule : tick_divider
`default_nettype wire

// ### cfg_device.sv
/*
 Device end: text and binary configuration command interpreter with a
 parameter table, nonvolatile copy and reply queue.
 Assumes the host delivers at most one byte per cycle and always takes
 reply bytes; bin_pin is asynchronous.
*/
// Added by the designer: the plain strobed port.
// Notes on behaviour
// - escape sequence with silences enters text mode
// - name without value reads, replies value
// - comma separated commands, one OK per line
// - text values are hexadecimal only
// - commit copies working set to nonvolatile
// - host matches baud, parity, stop settings
// - binary commands need input-2 function one
// - binary-program pin high selects binary mode
// - binary parameter two bytes, low first
// - binary command is one code byte
// - clear-to-send high while executing
// - host uses no hardware flow control
// - guard-after, idle timeout range and defaults
// - guard-before range two upward, default ten
// - wake initializer length one byte
// - wake initializer delay defaults all ones
// - network tag writable only 0x10-0x7FFF
// - hold-off threshold limited by buffer size
// - top bit set code reads parameter back
// - missing parameter bytes abandon after timeout
// - text command replies OK or ERROR
// - pin sampled once per received byte
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.svh"
module cfg_device #(
   parameter int unsigned TICK_CYC = `TICK_CYC,
   parameter logic [15:0] IN_BUF = 16'h0100,
   parameter logic [15:0] RST_RATE = 16'h0003,
   parameter logic [15:0] RST_TAG = 16'h3332
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Link
   cfg_link_if.dev link,
   // User side
   output logic [7:0] payload_data,
   output logic payload_valid,
   output logic cmd_mode,
   output logic nv_commit
);
   logic tick, pin_s1, pin_s2, rx_bin, rx_txt;
   logic [15:0] prm [0:63];
   logic [15:0] nv [0:63];
   logic [15:0] quiet, val, msg_val, wr_val;
   logic [7:0] c1, c2, blo;
   logic [7:0] txq [0:15];
   logic [7:0] msg [0:5];
   logic [2:0] nd, msg_len, btick;
   logic [1:0] esc_n;
   logic [3:0] wr_ptr, rd_ptr;
   logic [4:0] tx_n;
   logic [6:0] nc;
   logic [5:0] wr_code, bcode;
   logic [4:0] hexv;
   logic wr_en, commit, msg_push, line_act, line_err, leave_pend;
   cfg_pkg::text_state_t st;
   cfg_pkg::bin_state_t bst;
   cfg_pkg::msg_kind_t msg_kind;

   function automatic logic [15:0] reset_of(input int c);
      case (6'(c))
         `CODE_WAKE_DELAY: reset_of = `RST_WAKE_DELAY;
         `CODE_GUARD_BEFORE, `CODE_GUARD_AFTER: reset_of = `RST_GUARD;
         `CODE_IDLE_TIMEOUT: reset_of = `RST_IDLE_TIMEOUT;
         `CODE_WAKE_LEN: reset_of = `RST_WAKE_LEN;
         `CODE_MASK: reset_of = `RST_MASK;
         `CODE_ESC: reset_of = `RST_ESC;
         `CODE_RATE: reset_of = RST_RATE;
         `CODE_TAG: reset_of = RST_TAG;
         default: reset_of = `RST_ZERO;
      endcase
   endfunction : reset_of

   // Bit 6 marks a known code
   function automatic logic [6:0] name_code(input logic [15:0] n);
      case (n)
         `TXT_DEST: name_code = {1'b1, `CODE_DEST};
         `TXT_WAKE_DELAY: name_code = {1'b1, `CODE_WAKE_DELAY};
         `TXT_GUARD_BEFORE: name_code = {1'b1, `CODE_GUARD_BEFORE};
         `TXT_GUARD_AFTER: name_code = {1'b1, `CODE_GUARD_AFTER};
         `TXT_IDLE_TIMEOUT: name_code = {1'b1, `CODE_IDLE_TIMEOUT};
         `TXT_SW_HS: name_code = {1'b1, `CODE_SW_HS};
         `TXT_COMMIT: name_code = {1'b1, `CODE_COMMIT};
         `TXT_LEAVE: name_code = {1'b1, `CODE_LEAVE};
         `TXT_WAKE_LEN: name_code = {1'b1, `CODE_WAKE_LEN};
         `TXT_RX_FAIL: name_code = {1'b1, `CODE_RX_FAIL};
         `TXT_RX_GOOD: name_code = {1'b1, `CODE_RX_GOOD};
         `TXT_HOP: name_code = {1'b1, `CODE_HOP};
         `TXT_MASK: name_code = {1'b1, `CODE_MASK};
         `TXT_ESC: name_code = {1'b1, `CODE_ESC};
         `TXT_RATE: name_code = {1'b1, `CODE_RATE};
         `TXT_IN2: name_code = {1'b1, `CODE_IN2};
         `TXT_OUT2: name_code = {1'b1, `CODE_OUT2};
         `TXT_HOLD_OFF: name_code = {1'b1, `CODE_HOLD_OFF};
         `TXT_TAG: name_code = {1'b1, `CODE_TAG};
         `TXT_OUT3: name_code = {1'b1, `CODE_OUT3};
         default: name_code = 7'h00;
      endcase
   endfunction : name_code

   function automatic logic known(input logic [5:0] c);
      known = (c == `CODE_COMMIT) || (c == `CODE_LEAVE) || (reset_of(int'(c)) != `RST_ZERO)
         || (c == `CODE_DEST) || (c == `CODE_SW_HS) || (c == `CODE_RX_FAIL)
         || (c == `CODE_RX_GOOD) || (c == `CODE_HOP) || (c == `CODE_IN2)
         || (c == `CODE_OUT2) || (c == `CODE_HOLD_OFF) || (c == `CODE_OUT3)
         || (c == `CODE_RATE) || (c == `CODE_TAG);
   endfunction : known

   function automatic logic write_ok(input logic [5:0] c, input logic [15:0] v,
                                     input logic [15:0] cur);
      case (c)
         `CODE_GUARD_BEFORE, `CODE_GUARD_AFTER, `CODE_IDLE_TIMEOUT:
            write_ok = (v >= 16'h0002);
         `CODE_WAKE_LEN, `CODE_OUT3: write_ok = (c == `CODE_OUT3) ? (v <= 16'h0004)
            : (v <= 16'h00FF);
         `CODE_SW_HS: write_ok = (v <= 16'h0001);
         `CODE_HOP: write_ok = (v <= 16'h0006);
         `CODE_IN2: write_ok = (v <= 16'h0002);
         `CODE_OUT2: write_ok = (v <= 16'h0004);
         `CODE_ESC: write_ok = (v >= 16'h0020) && (v <= 16'h007F);
         `CODE_RATE: write_ok = (v <= 16'h0006) || (v >= 16'h007D);
         `CODE_HOLD_OFF: write_ok = (v <= IN_BUF - 16'h0011);
         `CODE_TAG: write_ok = (v >= 16'h0010) && (v <= 16'h7FFF) && !cur[15];
         `CODE_COMMIT, `CODE_LEAVE: write_ok = 1'b0;
         default: write_ok = known(c);
      endcase
   endfunction : write_ok

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction : hex_char

   tick_divider #(.DIV(TICK_CYC)) u_tick (.clk_sys(clk_sys), .sys_rst(sys_rst), .tick(tick));

   always_ff @(posedge clk_sys)
   begin
      pin_s1 <= link.bin_pin;
      pin_s2 <= pin_s1;
   end

   // Pin level taken with each byte; gated by input-2 function
   assign rx_bin = link.h_valid && pin_s2 && (prm[`CODE_IN2] == 16'h0001);
   assign rx_txt = link.h_valid && !rx_bin;
   assign nc = name_code({c1, c2});
   always_comb
   begin
      if (link.h_data >= 8'h30 && link.h_data <= 8'h39)
         hexv = {1'b1, link.h_data[3:0]};
      else if (link.h_data >= 8'h41 && link.h_data <= 8'h46)
         hexv = {1'b1, link.h_data[3:0] + 4'h9};
      else
         hexv = 5'h00;
   end
   assign link.cts_n = (tx_n != 5'h00) || msg_push || wr_en || commit
      || (st == cfg_pkg::P_FIN) || (bst != cfg_pkg::B_IDLE);
   assign cmd_mode = (st >= cfg_pkg::P_A);

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         quiet <= 16'h0000;
      else if (link.h_valid)
         quiet <= 16'h0000;
      else if (tick && quiet != 16'hFFFF)
         quiet <= quiet + 16'h0001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 64; i++)
            prm[i] <= reset_of(i);
         nv_commit <= 1'b0;
      end
      else
      begin
         nv_commit <= commit;
         if (wr_en)
            prm[wr_code] <= wr_val;
         if (commit)
            for (int i = 0; i < 64; i++)
               nv[i] <= prm[i];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         st <= cfg_pkg::P_DATA;
         bst <= cfg_pkg::B_IDLE;
         {c1, c2, blo, val, nd, esc_n, bcode, btick} <= '0;
         {line_act, line_err, leave_pend, wr_en, commit, msg_push} <= '0;
         {wr_code, wr_val, msg_val, payload_data, payload_valid} <= '0;
         msg_kind <= cfg_pkg::M_OK;
      end
      else
      begin
         wr_en <= 1'b0;
         commit <= 1'b0;
         msg_push <= 1'b0;
         payload_valid <= 1'b0;
         payload_data <= link.h_data;
         if (rx_txt && st < cfg_pkg::P_A)
            payload_valid <= 1'b1;
         if (st >= cfg_pkg::P_A && st != cfg_pkg::P_FIN && quiet >= prm[`CODE_IDLE_TIMEOUT])
            st <= cfg_pkg::P_DATA;
         else
            unique case (st)
               cfg_pkg::P_DATA:
                  if (rx_txt && link.h_data == prm[`CODE_ESC][7:0]
                      && quiet >= prm[`CODE_GUARD_BEFORE])
                  begin
                     st <= cfg_pkg::P_ESC;
                     esc_n <= 2'h1;
                  end
               cfg_pkg::P_ESC:
                  if (rx_txt)
                  begin
                     esc_n <= esc_n + 2'h1;
                     if (link.h_data != prm[`CODE_ESC][7:0])
                        st <= cfg_pkg::P_DATA;
                     else if (esc_n == 2'h2)
                        st <= cfg_pkg::P_GUARD;
                  end
               cfg_pkg::P_GUARD:
                  if (rx_txt)
                     st <= cfg_pkg::P_DATA;
                  else if (quiet >= prm[`CODE_GUARD_AFTER])
                  begin
                     st <= cfg_pkg::P_A;
                     msg_push <= 1'b1;
                     msg_kind <= cfg_pkg::M_OK;
                  end
               cfg_pkg::P_A:
                  if (rx_txt && link.h_data == `CH_A)
                     st <= cfg_pkg::P_T;
               cfg_pkg::P_T:
                  if (rx_txt)
                     st <= (link.h_data == `CH_T) ? cfg_pkg::P_L1 : cfg_pkg::P_A;
               cfg_pkg::P_L1:
                  if (rx_txt)
                  begin
                     c1 <= link.h_data;
                     st <= (link.h_data == `CH_CR) ? cfg_pkg::P_FIN : cfg_pkg::P_L2;
                  end
               cfg_pkg::P_L2:
                  if (rx_txt)
                  begin
                     c2 <= link.h_data;
                     val <= 16'h0000;
                     nd <= 3'h0;
                     // A one-letter name must still end the line, not swallow the next
                     st <= (link.h_data == `CH_CR) ? cfg_pkg::P_FIN : cfg_pkg::P_VAL;
                     line_err <= line_err || (link.h_data == `CH_CR);
                  end
               cfg_pkg::P_VAL:
                  if (rx_txt)
                  begin
                     if (hexv[4] && nd < 3'h4)
                     begin
                        val <= {val[11:0], hexv[3:0]};
                        nd <= nd + 3'h1;
                     end
                     else if (link.h_data == `CH_COMMA || link.h_data == `CH_CR)
                     begin
                        st <= (link.h_data == `CH_CR) ? cfg_pkg::P_FIN : cfg_pkg::P_L1;
                        // A bad character anywhere in the command blocks its execution
                        if (!nc[6] || line_err)
                           line_err <= 1'b1;
                        else if (nc[5:0] == `CODE_COMMIT)
                           {commit, line_act} <= 2'h3;
                        else if (nc[5:0] == `CODE_LEAVE)
                           {leave_pend, line_act} <= 2'h3;
                        else if (nd == 3'h0)
                        begin
                           msg_push <= 1'b1;
                           msg_kind <= cfg_pkg::M_VAL;
                           msg_val <= prm[nc[5:0]];
                        end
                        else if (write_ok(nc[5:0], val, prm[nc[5:0]]))
                        begin
                           {wr_en, line_act} <= 2'h3;
                           wr_code <= nc[5:0];
                           wr_val <= val;
                        end
                        else
                           line_err <= 1'b1;
                     end
                     else
                        line_err <= 1'b1;
                  end
               cfg_pkg::P_FIN:
               begin
                  msg_push <= line_err || line_act;
                  msg_kind <= line_err ? cfg_pkg::M_ERR : cfg_pkg::M_OK;
                  st <= leave_pend ? cfg_pkg::P_DATA : cfg_pkg::P_A;
                  {line_err, line_act, leave_pend} <= 3'h0;
               end
            endcase
         unique case (bst)
            cfg_pkg::B_IDLE:
               if (rx_bin)
               begin
                  bcode <= link.h_data[5:0];
                  btick <= 3'h0;
                  if ((link.h_data & `BIN_READ_FLAG) != 8'h00)
                  begin
                     if (known(link.h_data[5:0]) && !link.h_data[6])
                     begin
                        msg_push <= 1'b1;
                        msg_kind <= cfg_pkg::M_BIN;
                        msg_val <= prm[link.h_data[5:0]];
                     end
                  end
                  else if (link.h_data[5:0] == `CODE_COMMIT && link.h_data[7:6] == 2'h0)
                     commit <= 1'b1;
                  else if (link.h_data[5:0] != `CODE_LEAVE && known(link.h_data[5:0])
                           && !link.h_data[6])
                     bst <= cfg_pkg::B_LO;
               end
            cfg_pkg::B_LO, cfg_pkg::B_HI:
               if (tick && btick == 3'(`BIN_TIMEOUT_TICKS - 1))
                  bst <= cfg_pkg::B_IDLE;
               else
               begin
                  if (tick)
                     btick <= btick + 3'h1;
                  if (rx_bin && bst == cfg_pkg::B_LO)
                  begin
                     blo <= link.h_data;
                     bst <= cfg_pkg::B_HI;
                  end
                  else if (rx_bin)
                  begin
                     bst <= cfg_pkg::B_IDLE;
                     wr_en <= write_ok(bcode, {link.h_data, blo}, prm[bcode]);
                     wr_code <= bcode;
                     wr_val <= {link.h_data, blo};
                  end
               end
            default: bst <= cfg_pkg::B_IDLE;
         endcase
      end
   end

   always_comb
   begin
      msg_len = 3'h0;
      for (int i = 0; i < 6; i++)
         msg[i] = `CH_CR;
      unique case (msg_kind)
         cfg_pkg::M_OK:
         begin
            {msg[0], msg[1]} = {`CH_O, `CH_K};
            msg_len = 3'h3;
         end
         cfg_pkg::M_ERR:
         begin
            {msg[0], msg[1], msg[2], msg[3], msg[4]} = {`CH_E, `CH_R, `CH_R, `CH_O, `CH_R};
            msg_len = 3'h6;
         end
         cfg_pkg::M_VAL:
         begin
            msg_len = (msg_val[15:12] != 4'h0) ? 3'h5 : (msg_val[15:8] != 8'h00) ? 3'h4
               : (msg_val[15:4] != 12'h000) ? 3'h3 : 3'h2;
            for (int i = 0; i < 4; i++)
               if (i < int'(msg_len) - 1)
                  msg[i] = hex_char(4'(msg_val >> (4 * (int'(msg_len) - 2 - i))));
         end
         cfg_pkg::M_BIN:
         begin
            {msg[0], msg[1]} = {msg_val[7:0], msg_val[15:8]};
            msg_len = 3'h2;
         end
      endcase
   end

   // Queue overruns only if the host ignores the hold-off
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         {wr_ptr, rd_ptr, tx_n} <= '0;
         link.d_valid <= 1'b0;
         link.d_data <= 8'h00;
      end
      else
      begin
         link.d_valid <= (tx_n != 5'h00);
         if (tx_n != 5'h00)
         begin
            link.d_data <= txq[rd_ptr];
            rd_ptr <= rd_ptr + 4'h1;
         end
         if (msg_push)
         begin
            for (int i = 0; i < 6; i++)
               if (i < int'(msg_len))
                  txq[4'(int'(wr_ptr) + i)] <= msg[i];
            wr_ptr <= wr_ptr + {1'b0, msg_len};
         end
         tx_n <= tx_n + (msg_push ? {2'h0, msg_len} : 5'h00) - ((tx_n != 5'h00) ? 5'h01 : 5'h00);
      end
   end
endmodule : cfg_device
`default_nettype wire

// ### cfg_host.sv
/*
 Host end: software-driven relay onto the configuration link through
 four registers on a plain strobe port. Reply bytes are same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.svh"
module cfg_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Link
   cfg_link_if.host link
);
   logic [7:0] rx_byte;
   logic rx_full, rx_lost;

   // Sends regardless of the hold-off, so binary parameters flow freely
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         link.h_valid <= 1'b0;
         link.h_data <= 8'h00;
         link.bin_pin <= 1'b0;
      end
      else
      begin
         link.h_valid <= wr && addr == `HREG_TX;
         if (wr && addr == `HREG_TX)
            link.h_data <= wdata[7:0];
         if (wr && addr == `HREG_PIN)
            link.bin_pin <= wdata[0];
      end
   end

   // Arrival wins over the clearing read
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rx_byte <= 8'h00;
         rx_full <= 1'b0;
         rx_lost <= 1'b0;
      end
      else
      begin
         if (link.d_valid)
         begin
            rx_byte <= link.d_data;
            rx_full <= 1'b1;
            rx_lost <= rx_lost || (rx_full && !(rd && addr == `HREG_RX));
         end
         else if (rd && addr == `HREG_RX)
            rx_full <= 1'b0;
         if (rd && addr == `HREG_STATUS && !link.d_valid)
            rx_lost <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         rdata <= 32'h0000_0000;
      else if (rd)
         unique case (addr)
            `HREG_PIN: rdata <= {31'h0, link.bin_pin};
            `HREG_RX: rdata <= {23'h0, rx_full, rx_byte};
            `HREG_STATUS: rdata <= {29'h0, rx_lost, rx_full, link.cts_n};
            default: rdata <= 32'h0000_0000;
         endcase
      else
         rdata <= 32'h0000_0000;
   end
endmodule : cfg_host
`default_nettype wire

// ### cfg_link_assertions.sv
/* Checker for the host-device byte link.
   Assumes in2_func_sel is 1 whenever bin_pin is raised. */
`timescale 1ns/1ps
`default_nettype none
module cfg_link_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Link
   input wire logic [7:0] h_data,
   input wire logic h_valid,
   input wire logic bin_pin,
   input wire logic [7:0] d_data,
   input wire logic d_valid,
   input wire logic cts_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [8:0] d;
   assign d = {d_valid, d_data};
   // Pin given three cycles to pass the synchroniser
   sequence s_cmd;
      $past(bin_pin, 3) && bin_pin && h_valid;
   endsequence
   sequence s_er;
      d == 9'h145 && !bin_pin ##1 d == 9'h152;
   endsequence
   property p_rst_quiet; $fell(sys_rst) |-> !d_valid && !h_valid && !cts_n; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("link busy after reset");
   property p_ok; d == 9'h14F && !bin_pin && !$past(d_valid) |=> d == 9'h14B ##1 d == 9'h10D; endproperty
   a_ok: assert property (p_ok) else $error("bad OK reply");
   property p_err; s_er |=> d == 9'h152 ##1 d == 9'h14F ##1 d == 9'h152 ##1 d == 9'h10D; endproperty
   a_err: assert property (p_err) else $error("bad ERROR reply");
   property p_end_cr; d_valid && !bin_pin ##1 !d_valid |-> $past(d_data) == 8'h0D; endproperty
   a_end_cr: assert property (p_end_cr) else $error("reply not ended by CR");
   property p_cr_reply; h_valid && h_data == 8'h0D && !bin_pin |-> ##[1:10] d_valid; endproperty
   a_cr_reply: assert property (p_cr_reply) else $error("no reply to line");
   property p_bin_silent; s_cmd ##0 !h_data[7] |=> !d_valid [*5]; endproperty
   a_bin_silent: assert property (p_bin_silent) else $error("reply to write");
   property p_bin_read; s_cmd ##0 h_data[7] |-> ##[2:4] d_valid ##1 d_valid ##1 !d_valid; endproperty
   a_bin_read: assert property (p_bin_read) else $error("read reply not two bytes");
   property p_cts_busy; s_cmd ##0 h_data == 8'h00 |-> ##[0:3] cts_n; endproperty
   a_cts_busy: assert property (p_cts_busy) else $error("not busy while collecting");
endmodule : cfg_link_assertions
`default_nettype wire

// ### serial_config_command_parser_tb_top.sv
/* Testbench: host and device ends joined by the link.
   Assumes a short tick so that guard times last about a hundred cycles. */
`timescale 1ns/1ps
`default_nettype none
module serial_config_command_parser_tb_top;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, r;
   logic [7:0] payload_data, pl;
   logic payload_valid, nv_commit, cmd_mode;
   logic [15:0] v;
   logic [7:0] rq[$];
   int error_cnt = 0;
   int compares = 0;
   int ncom = 0;
   string bad[6] = '{"ATAT1", "ATBT1", "ATID8000", "ATID0F", "ATFTF0", "ATDT1G2"};
   cfg_link_if lnk();
   cfg_device #(.TICK_CYC(10)) i_cfg_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(lnk.dev),
      .payload_data(payload_data), .payload_valid(payload_valid), .cmd_mode(cmd_mode),
      .nv_commit(nv_commit));
   cfg_host i_cfg_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .link(lnk.host));
   cfg_link_assertions i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .h_data(lnk.h_data),
      .h_valid(lnk.h_valid), .bin_pin(lnk.bin_pin), .d_data(lnk.d_data), .d_valid(lnk.d_valid),
      .cts_n(lnk.cts_n));
   always #10 clk_sys = ~clk_sys;
   // Replies come back to back, faster than the RX register can be polled
   always @(posedge clk_sys)
   begin
      if (lnk.d_valid === 1'b1) rq.push_back(lnk.d_data);
      if (nv_commit === 1'b1) ncom++;
      if (payload_valid === 1'b1) pl = payload_data;
   end
   task automatic end_sim;
      $display("Errors %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk
   function automatic string hx(input logic [15:0] x);
      string t;
      t = $sformatf("%0h", x);
      return t.toupper();
   endfunction : hx
   task automatic bw(input logic [3:0] a, input logic [31:0] dt);
      @(posedge clk_sys);
      addr <= a;
      wdata <= dt;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : bw
   task automatic br(input logic [3:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      r = rdata;
   endtask : br
   task automatic cmp(input string e);
      chk(rq.size(), e.len());
      foreach (rq[i]) chk(rq[i], e[i]);
      rq = {};
   endtask : cmp
   task automatic line(input string s, input string e);
      foreach (s[i]) bw(4'h0, {24'h0, s[i]});
      bw(4'h0, 32'h0D);
      repeat (30) @(posedge clk_sys);
      cmp({e, "\015"});
   endtask : line
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      end_sim();
   end
   initial
   begin
      void'($urandom(32'h3A4CC169));
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (120) @(posedge clk_sys);
      repeat (3) bw(4'h0, 32'h2B);
      repeat (130) @(posedge clk_sys);
      cmp("OK\015");
      chk(cmd_mode, 1'b1);
      line("ATDT", "0");
      v = 16'($urandom);
      line({"ATDT", hx(v)}, "OK");
      line("ATDT", hx(v));
      foreach (bad[i]) line(bad[i], "ERROR");
      line("ATDT", hx(v));
      line("ATBT", "A");
      line("ATHT", "FFFF");
      line("ATCT", "C8");
      line("ATLH", "1");
      line("ATRT1", "OK");
      line("ATDT1A0D,WR,CN", "OK");
      chk(ncom, 1);
      chk(cmd_mode, 1'b0);
      bw(4'h0, 32'h5A);
      chk(pl, 8'h5A);
      bw(4'h4, 32'h1);
      v = 16'($urandom) & 16'h7F7F | 16'h0101;
      bw(4'h0, 32'h00);
      bw(4'h0, {24'h0, v[7:0]});
      bw(4'h0, {24'h0, v[15:8]});
      bw(4'h0, 32'h80);
      repeat (10) @(posedge clk_sys);
      cmp(string'({v[7:0], v[15:8]}));
      br(4'h8);
      chk(r, {23'h0, 1'b1, v[15:8]});
      br(4'hC);
      chk(r, 32'h4);
      br(4'h2);
      chk(r, 32'h0);
      bw(4'h0, 32'h08);
      repeat (5) @(posedge clk_sys);
      chk(ncom, 2);
      bw(4'h0, 32'h00);
      repeat (80) @(posedge clk_sys);
      bw(4'h0, 32'h80);
      repeat (10) @(posedge clk_sys);
      cmp(string'({v[7:0], v[15:8]}));
      bw(4'h4, 32'h0);
      end_sim();
   end
endmodule : serial_config_command_parser_tb_top
`default_nettype wire
